// [src/stream_par_port_params.svh]
// Offsets, field positions, reset values and timing counts of the parallel port
// Assumes a 32-bit AXI4-Lite register slave with one register per aligned word
`ifndef STREAM_PAR_PORT_PARAMS_SVH
`define STREAM_PAR_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_CONTROL 5'h00
`define OFS_PORT_CONFIG 5'h04
`define OFS_EP_ADDR_STATUS 5'h08
`define OFS_PORT_DATA 5'h0C
`define OFS_IRQ_FLAGS 5'h10
`define OFS_IRQ_ENABLES 5'h14
`define OFS_IRQ_PRIORITIES 5'h18
`define OFS_PORT_E_LATCH 5'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_OWNER 1
`define CFG_WAIT 3:0
`define CFG_STROBE1_EN 4
`define CFG_CS_EN 5
`define CFG_STROBE 7:6
`define EPS_ADDR 3:0
`define EPS_BUSY 4
`define EPS_LAST_WRITE 6
`define EPS_LAST_READ 7
`define IRQ_PORT_BIT 7
`define PULLUP_BIT 7

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define CONTROL_RST 2'h0
`define CONFIG_RST 8'h00
`define EP_ADDR_RST 4'h0
`define DATA_RST 8'h00
`define STROBE_ADDR_DATA 2'h0
`define STROBE_WR_RD 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing: instruction rate is the oscillator over four
// ----------------------------------------------------------------
`define INSTR_DIV_LAST 2'h3

`endif

// [src/par_port_pkg.sv]
// Types shared by the parallel port design
// Assumes the constants header is included by the modules that need numbers
package par_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } xfer_state_t;

  typedef struct packed {
    logic write;
    logic is_addr;
    logic [3:0] ep;
    logic [7:0] data;
  } xfer_req_t;

  typedef struct packed {
    logic strobe1;
    logic strobe2;
    logic chip_sel;
    logic out_en;
  } ctl_pins_t;

endpackage : par_port_pkg

// [src/wait_phase_timer.sv]
// Counts source-clock ticks of one transaction phase
// Assumes tick is a one-cycle pulse on mclk from the data source clock
`timescale 1ns/100ps
module wait_phase_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [3:0] half_wait,
  // Phase end pulse
  output logic phase_end
);

  logic [3:0] cnt_q;

  // Phase is one base tick plus half of the wait states
  assign phase_end = tick & ~restart & (cnt_q == half_wait);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 4'h0;
    else if (restart || phase_end)
      cnt_q <= 4'h0;
    else if (tick)
      cnt_q <= cnt_q + 4'h1;
  end

endmodule : wait_phase_timer

// [src/stream_par_port.sv]
// Streaming parallel master port with AXI4-Lite registers and a USB engine feed
// Assumes the USB engine pulses usb_tick on mclk and keeps its request stable
//
// Operation
// (RULE1) Wait ticks from USB or instruction clock
// (RULE2) Wait states zero to thirty, step two
// (RULE3) Half the waits after each phase
// (RULE4) Data pull-ups follow port E bit
// (RULE5) USB owner streams address then data
// (RULE6) Firmware sets up USB ownership in order
// (RULE7) Routed endpoints are isochronous only
// (RULE8) Processor owner uses data and status registers
// (RULE9) Firmware sets up processor ownership in order
// (RULE10) Processor completion sets gated priority flag
// (RULE11) Status write starts address, data write data; address cycle here only in address/data strobe mode
// (RULE12) Busy bit high during any cycle
// (RULE13) Firmware polls busy before each write
// (RULE14) First data read starts, completion loads
// (RULE15) Later reads return previous, start next
// (RULE16) Endpoint address four bits, plain binary
// (RULE17) Last-read bit marks a USB read
// (RULE18) Last-write bit marks a USB write
// (RULE19) Owner bit selects master, enable gates port
// (RULE20) Strobe mode picks which strobe fires
// (RULE21) Pin enables hand pins to port
// (RULE22) Busy drops after the last wait tick
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "stream_par_port_params.svh"
module stream_par_port
  import par_port_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // AXI4-Lite register slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // USB engine stream
  input wire logic usb_tick,
  input wire xfer_req_t usb_req,
  input wire logic usb_req_valid,
  output logic usb_req_ready,
  output logic [7:0] usb_rd_data,
  output logic usb_done,
  // Parallel pins
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe_b,
  output logic data_pullup_en,
  output ctl_pins_t ctl_pins,
  output logic cs_pin_sel,
  output logic strobe1_pin_sel,
  // Interrupt requests
  output logic irq_high,
  output logic irq_low
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  function automatic logic pick_strobe1(input logic [1:0] mode, input xfer_req_t r);
    if (mode[1])
      pick_strobe1 = r.ep[0];
    else if (mode == `STROBE_WR_RD)
      pick_strobe1 = r.write;
    else
      pick_strobe1 = r.is_addr;
  endfunction : pick_strobe1

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [3:0] ep_q;
  logic last_rd_q, last_wr_q;
  logic [7:0] data_q;
  logic irq_flag_q, irq_en_q, irq_prio_q, pullup_q;
  logic [7:0] pd_meta_q, pd_sync_q;
  logic [1:0] div_q;
  xfer_state_t state_q;
  xfer_req_t cur_q;
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q, rvalid_q, usb_done_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  logic enable, owner_usb, busy, tick, phase_end, done;
  logic wr_fire, ar_fire, wr_ok, cpu_ok;
  logic cpu_addr_start, cpu_data_start, cpu_rd_start, usb_start, start;
  xfer_req_t next_req;

  assign enable = ctrl_q[`CTL_ENABLE];
  assign owner_usb = ctrl_q[`CTL_OWNER];
  assign busy = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // Pin input synchroniser and source tick
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_meta_q <= 8'h00;
      pd_sync_q <= 8'h00;
    end
    else
    begin
      pd_meta_q <= pd_in;
      pd_sync_q <= pd_meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  assign tick = owner_usb ? usb_tick : (div_q == `INSTR_DIV_LAST); // RULE1 RULE8

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign awready = ~aw_full_q;
  assign wready = ~w_full_q;
  assign arready = ~rvalid_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign ar_fire = arvalid & ~rvalid_q;
  assign wr_ok = wr_fire & w_lane0_q & reg_hit(aw_addr_q);
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (wr_fire)
        aw_full_q <= 1'b0;
      if (wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_lane0_q <= wstrb[0];
      end
      else if (wr_fire)
        w_full_q <= 1'b0;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= reg_hit(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else if (ar_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q <= 32'h0000_0000;
      unique case (araddr[4:0])
        `OFS_PORT_CONTROL: rdata_q[1:0] <= ctrl_q;
        `OFS_PORT_CONFIG: rdata_q[7:0] <= cfg_q;
        `OFS_EP_ADDR_STATUS: rdata_q[7:0] <= {last_rd_q, last_wr_q, 1'b0, busy, ep_q}; // RULE16
        `OFS_PORT_DATA: rdata_q[7:0] <= data_q; // RULE15
        `OFS_IRQ_FLAGS: rdata_q[`IRQ_PORT_BIT] <= irq_flag_q;
        `OFS_IRQ_ENABLES: rdata_q[`IRQ_PORT_BIT] <= irq_en_q;
        `OFS_IRQ_PRIORITIES: rdata_q[`IRQ_PORT_BIT] <= irq_prio_q;
        default: rdata_q[`PULLUP_BIT] <= pullup_q;
      endcase
      if (!reg_hit(araddr))
        rdata_q <= 32'h0000_0000;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `CONTROL_RST;
      cfg_q <= `CONFIG_RST;
      ep_q <= `EP_ADDR_RST;
      irq_en_q <= 1'b0;
      irq_prio_q <= 1'b0;
      pullup_q <= 1'b0;
    end
    else if (wr_ok)
    begin
      unique case (aw_addr_q[4:0])
        `OFS_PORT_CONTROL: ctrl_q <= w_data_q[1:0]; // RULE19
        `OFS_PORT_CONFIG: cfg_q <= w_data_q[7:0];
        `OFS_EP_ADDR_STATUS: ep_q <= w_data_q[`EPS_ADDR];
        `OFS_IRQ_ENABLES: irq_en_q <= w_data_q[`IRQ_PORT_BIT];
        `OFS_IRQ_PRIORITIES: irq_prio_q <= w_data_q[`IRQ_PORT_BIT];
        `OFS_PORT_E_LATCH: pullup_q <= w_data_q[`PULLUP_BIT];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transaction starts
  // ----------------------------------------------------------------
  assign cpu_ok = enable & ~owner_usb & ~busy; // RULE8
  assign cpu_addr_start = cpu_ok & wr_ok & (aw_addr_q[4:0] == `OFS_EP_ADDR_STATUS)
    & (cfg_q[`CFG_STROBE] == `STROBE_ADDR_DATA); // RULE11
  assign cpu_data_start = cpu_ok & wr_ok & (aw_addr_q[4:0] == `OFS_PORT_DATA); // RULE11
  assign cpu_rd_start = cpu_ok & ~wr_ok & ar_fire & (araddr == {3'h0, `OFS_PORT_DATA}); // RULE14 RULE15
  assign usb_req_ready = enable & owner_usb & ~busy; // RULE5
  assign usb_start = usb_req_valid & usb_req_ready; // RULE5
  assign start = cpu_addr_start | cpu_data_start | cpu_rd_start | usb_start;

  always_comb
  begin
    next_req = usb_req;
    // Address cycles put the endpoint on the data lines
    if (usb_req.is_addr)
      next_req.data = {4'h0, usb_req.ep}; // RULE5
    if (!usb_start)
    begin
      next_req.write = cpu_addr_start | cpu_data_start;
      next_req.is_addr = cpu_addr_start;
      next_req.ep = cpu_addr_start ? w_data_q[`EPS_ADDR] : ep_q;
      next_req.data = cpu_addr_start ? {4'h0, w_data_q[`EPS_ADDR]} : w_data_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  wait_phase_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    // Held clear while idle so no phase end fires outside a transaction
    .restart(start | ~busy),
    .tick(tick),
    .half_wait(cfg_q[`CFG_WAIT]), // RULE2 RULE3
    .phase_end(phase_end)
  );

  assign done = (state_q == ST_SECOND) & phase_end; // RULE22

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_IDLE;
    else if (!enable)
      state_q <= ST_IDLE; // RULE19
    else
    begin
      unique case (state_q)
        ST_IDLE: if (start) state_q <= ST_FIRST; // RULE12
        ST_FIRST: if (phase_end) state_q <= ST_SECOND; // RULE3
        ST_SECOND: if (phase_end) state_q <= ST_IDLE; // RULE22
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cur_q <= '0;
    else if (start)
      cur_q <= next_req;
  end

  // Completion effects
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_q <= `DATA_RST;
      last_rd_q <= 1'b0;
      last_wr_q <= 1'b0;
      usb_done_q <= 1'b0;
    end
    else
    begin
      usb_done_q <= done & owner_usb;
      if (done && !cur_q.write)
        data_q <= pd_sync_q; // RULE14
      if (done && owner_usb)
      begin
        last_rd_q <= ~cur_q.write; // RULE17
        last_wr_q <= cur_q.write; // RULE18
      end
    end
  end

  // Hardware set wins over software clear
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      irq_flag_q <= 1'b0;
    else if (done && !owner_usb)
      irq_flag_q <= 1'b1; // RULE10
    else if (wr_ok && aw_addr_q[4:0] == `OFS_IRQ_FLAGS && !w_data_q[`IRQ_PORT_BIT])
      irq_flag_q <= 1'b0;
  end

  assign irq_high = irq_flag_q & irq_en_q & irq_prio_q; // RULE10
  assign irq_low = irq_flag_q & irq_en_q & ~irq_prio_q; // RULE10
  assign usb_done = usb_done_q;
  assign usb_rd_data = data_q;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic fire1;
  assign fire1 = pick_strobe1(cfg_q[`CFG_STROBE], cur_q); // RULE20
  assign strobe1_pin_sel = enable & cfg_q[`CFG_STROBE1_EN]; // RULE21
  assign cs_pin_sel = enable & cfg_q[`CFG_CS_EN]; // RULE21
  assign ctl_pins.strobe1 = (state_q == ST_FIRST) & fire1 & strobe1_pin_sel; // RULE20
  assign ctl_pins.strobe2 = (state_q == ST_FIRST) & ~fire1;
  assign ctl_pins.chip_sel = busy & cs_pin_sel;
  assign ctl_pins.out_en = busy & ~cur_q.write;
  assign pd_out = cur_q.data;
  assign pd_oe_b = ~(busy & cur_q.write);
  assign data_pullup_en = pullup_q; // RULE4

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] ph_ticks_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ph_ticks_q <= 5'h00;
    else if (start || phase_end)
      ph_ticks_q <= 5'h00;
    else if (busy && tick)
      ph_ticks_q <= ph_ticks_q + 5'h01;
  end

  busy_rise_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE12
    start && enable |=> busy) else $error("busy not raised on start");
  busy_fall_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE22
    $fell(busy) && enable |-> $past(done)) else $error("busy dropped early");
  phase_len_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
    phase_end |-> ph_ticks_q == {1'b0, cfg_q[`CFG_WAIT]}) else $error("phase length wrong");
  tick_src_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
    !owner_usb && div_q != `INSTR_DIV_LAST |-> !phase_end) else $error("phase off tick");
  irq_set_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
    done && !owner_usb |=> irq_flag_q) else $error("flag not set");
  read_load_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
    done && !cur_q.write |=> data_q == $past(pd_sync_q)) else $error("read byte lost");
  addr_cycle_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE11
    cpu_addr_start |=> cur_q.is_addr && cur_q.write && busy) else $error("no address cycle");
  strobe_mode_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE20
    ctl_pins.strobe1 && cfg_q[7:6] == `STROBE_ADDR_DATA |-> cur_q.is_addr)
    else $error("strobe1 on data");
  usb_last_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE18
    done && owner_usb |=> last_wr_q == $past(cur_q.write) && usb_done)
    else $error("usb status wrong");
  port_off_a: assert property (@(posedge mclk) disable iff (!rst_b) // RULE19
    !enable |=> !ctl_pins.strobe2 && !ctl_pins.out_en) else $error("pins live when off");

endmodule : stream_par_port

// [test/par_slave_model.sv]
// Behavioural slave device on the parallel data and control pins
// Assumes active-high control pins and a bench that sets the byte to return
`timescale 1ns/100ps
module par_slave_model
  import par_port_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Port pins
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_b,
  input wire logic data_pullup_en,
  input wire ctl_pins_t ctl_pins,
  output logic [7:0] pd_in,
  // Bench side
  input wire logic [7:0] rd_byte,
  output logic [7:0] wr_byte
);
  // ----------------------------------------------------------------
  // Data lines
  // ----------------------------------------------------------------
  logic [7:0] last_q = 8'h00;

  // Released lines float high with pull-ups, else toggle and never hold the last byte
  assign pd_in = ctl_pins.out_en ? rd_byte : (data_pullup_en ? 8'hFF : ~last_q);

  always_ff @(posedge mclk)
  begin
    last_q <= pd_in;
    if (!pd_oe_b)
    begin
      wr_byte <= pd_out;
    end
  end
endmodule : par_slave_model

// [test/test_stream_par_port.sv]
// Self-checking bench for the streaming parallel port
// Assumes the slave model file and the design package are compiled first
`timescale 1ns/100ps
module test_stream_par_port
  import par_port_pkg::*;
  ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    xfer_req_t req;
    logic sel1;
  } row_t;
  row_t rows [6] = '{
    '{8'h30, '{1'b1, 1'b1, 4'h5, 8'h00}, 1'b1},
    '{8'h31, '{1'b1, 1'b0, 4'h5, 8'hA5}, 1'b0},
    '{8'h72, '{1'b1, 1'b0, 4'h2, 8'h5C}, 1'b1},
    '{8'h77, '{1'b0, 1'b0, 4'h2, 8'h00}, 1'b0},
    '{8'hBF, '{1'b0, 1'b0, 4'h3, 8'h00}, 1'b1},
    '{8'hF1, '{1'b1, 1'b0, 4'h4, 8'h96}, 1'b0}
  };
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic usb_tick = 1'b1;
  xfer_req_t usb_req = '0;
  logic usb_req_valid = 1'b0;
  logic usb_req_ready, usb_done;
  logic [7:0] usb_rd_data, pd_in, pd_out, wr_byte;
  logic [7:0] rd_byte = 8'h00;
  logic pd_oe_b, data_pullup_en, cs_pin_sel, strobe1_pin_sel, irq_high, irq_low;
  ctl_pins_t ctl_pins;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  stream_par_port u_stream_par_port (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .usb_tick(usb_tick), .usb_req(usb_req), .usb_req_valid(usb_req_valid),
    .usb_req_ready(usb_req_ready), .usb_rd_data(usb_rd_data), .usb_done(usb_done),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe_b(pd_oe_b), .data_pullup_en(data_pullup_en),
    .ctl_pins(ctl_pins), .cs_pin_sel(cs_pin_sel), .strobe1_pin_sel(strobe1_pin_sel),
    .irq_high(irq_high), .irq_low(irq_low));

  par_slave_model u_par_slave_model (.mclk(mclk), .pd_out(pd_out), .pd_oe_b(pd_oe_b),
    .data_pullup_en(data_pullup_en), .ctl_pins(ctl_pins), .pd_in(pd_in),
    .rd_byte(rd_byte), .wr_byte(wr_byte));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk);
      aw_ok = aw_ok || awready === 1'b1;
      w_ok = w_ok || wready === 1'b1;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    while (bvalid !== 1'b1)
      @(posedge mclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge mclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge mclk);
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(name, exp, d & mask);
  endtask : rd_chk

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 100; k++)
    begin
      axi_rd(8'h08, d, r);
      if (d[4] === 1'b0)
        break;
    end
    chk("busy clears", 32'h0, d & 32'h10);
  endtask : wait_idle

  task automatic usb_xfer(input xfer_req_t q, output int s1, output int s2, output int cs,
                          output logic [7:0] rdv);
    @(posedge mclk);
    usb_req <= q;
    usb_req_valid <= 1'b1;
    do
      @(posedge mclk);
    while (usb_req_ready !== 1'b1);
    usb_req_valid <= 1'b0;
    s1 = 0;
    s2 = 0;
    cs = 0;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge mclk);
      s1 += ctl_pins.strobe1;
      s2 += ctl_pins.strobe2;
      cs += ctl_pins.chip_sel;
      if (usb_done === 1'b1)
        break;
    end
    rdv = usb_rd_data;
  endtask : usb_xfer

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n, s1, s2, cs;
    logic [7:0] rdv;
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    wr(8'h04, {24'h0, rows[0].cfg});
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    for (int i = 0; i < 6; i++)
    begin
      n = rows[i].cfg[3:0];
      rd_byte <= 8'h3C ^ 8'(i);
      wr(8'h04, {24'h0, rows[i].cfg});
      usb_xfer(rows[i].req, s1, s2, cs, rdv);
      chk("strobe1 cycles", rows[i].sel1 ? n + 1 : 0, s1);
      chk("strobe2 cycles", rows[i].sel1 ? 0 : n + 1, s2);
      chk("select cycles", 2 * n + 2, cs);
      if (rows[i].req.write)
        chk("slave byte", rows[i].req.is_addr ? rows[i].req.ep : rows[i].req.data, wr_byte);
      else
        chk("usb read", 8'h3C ^ 8'(i), rdv);
      rd_chk("last dir", 8'h08, 32'hC0, {rows[i].req.write ? 2'b01 : 2'b10, 6'h0});
    end
    rd_chk("no flag usb", 8'h10, 32'h80, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h33);
    wr(8'h00, 32'h1);
    chk("cs pin", 1, cs_pin_sel);
    chk("strobe1 pin", 1, strobe1_pin_sel);
    wr(8'h0C, 32'h5A);
    rd_chk("busy set", 8'h08, 32'h10, 32'h10);
    wait_idle();
    chk("data byte", 8'h5A, wr_byte);
    rd_chk("irq flag", 8'h10, 32'h80, 32'h80);
    wr(8'h14, 32'h80);
    chk("irq low", 1, irq_low);
    chk("irq high off", 0, irq_high);
    wr(8'h18, 32'h80);
    chk("irq high", 1, irq_high);
    wr(8'h10, 32'h0);
    chk("irq cleared", 0, irq_high);
    wr(8'h08, 32'h9);
    wait_idle();
    chk("addr byte", 8'h09, wr_byte);
    rd_byte <= 8'h3C;
    axi_rd(8'h0C, d, r);
    wait_idle();
    rd_byte <= 8'hC3;
    rd_chk("first read", 8'h0C, 32'hFF, 32'h3C);
    wait_idle();
    rd_chk("next read", 8'h0C, 32'hFF, 32'hC3);
    wait_idle();
    wr(8'h00, 32'h0);
    chk("cs pin off", 0, cs_pin_sel);
    wr(8'h0C, 32'h77);
    rd_chk("idle off", 8'h08, 32'h10, 32'h0);
    chk("no write off", 8'h09, wr_byte);
    wr(8'h1C, 32'h80);
    chk("pullup", 1, data_pullup_en);
    axi_wr(8'h20, 32'h1, r);
    chk("bresp unmapped", `RESP_SLVERR, r);
    axi_rd(8'h20, d, r);
    chk("rresp unmapped", `RESP_SLVERR, r);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    chk("oe reset", 1, pd_oe_b);
    chk("pullup reset", 0, data_pullup_en);
    rd_chk("control reset", 8'h00, 32'hFF, 32'h0);
    rd_chk("config reset", 8'h04, 32'hFF, 32'h0);
    rd_chk("status reset", 8'h08, 32'hFF, 32'h0);
    final_report();
  end
endmodule : test_stream_par_port
